// ---- hw/idle_power_control_regs.svh ----
// Register map, field positions and timing constants of the power control block
`ifndef IDLE_POWER_CONTROL_REGS_SVH
`define IDLE_POWER_CONTROL_REGS_SVH

// ==========================================================
// Bus geometry
`define APB_ADDR_W 12
`define APB_DATA_W 32
`define WORD_INDEX_W 10

// ==========================================================
// Register indices, byte address is four times the index
`define POWER_CONTROL_INDEX 10'h087
`define WATCHDOG_CTRL_INDEX 10'h088
`define SLEEP_STATUS_INDEX 10'h089

// ==========================================================
// Power control register fields
`define SLEEP_CPU_CLOCK_BIT 0
`define POWER_DOWN_REQUEST 1
`define SPARE_FLAG_ZERO 2
`define SPARE_FLAG_ONE 3
`define COLD_START_FLAG 4
`define WAKE_TIMING_SELECT 5
`define FRAME_ERROR_VIEW_SELECT 6
`define BAUD_DOUBLER 7
`define POWER_CONTROL_RESET 8'h00
`define COLD_START_RESET 1'b1

// ==========================================================
// Own control and status fields
`define WATCHDOG_SLEEP_RUN 0
`define WATCHDOG_CTRL_RESET 1'b0
`define STATUS_STATE_LSB 0
`define STATUS_STATE_MSB 1
`define STATUS_CPU_GATED 2
`define STATUS_WAKE_PIN 3

// ==========================================================
// Start-up timer
`define CLOCK_PERIOD_NS 25
`define STARTUP_TIME_NS 16000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STARTUP_CNT_W 10

`endif

// ---- hw/idle_power_control_pkg.sv ----
// Types shared by the power control block
package idle_power_control_pkg;

    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_idle = 2'b01,
        st_power_down = 2'b10,
        st_wake_wait = 2'b11
    } power_state_e;

    typedef logic [7:0] power_control_t;

endpackage

// ---- hw/startup_timer_if.sv ----
// Handshake between the sequencer and its start-up timer
`timescale 1ns/100ps

interface startup_timer_if;
    logic start;
    logic done;

    modport ctrl (
        output start,
        input done
    );

    modport timer (
        input start,
        output done
    );
endinterface

// ---- hw/startup_timer.sv ----
// Start-up timer that counts a fixed settle time after a start pulse
`timescale 1ns/100ps
`include "idle_power_control_regs.svh"

module startup_timer (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_clock_en,
    startup_timer_if.timer tmr
);

    logic [`STARTUP_CNT_W-1:0] count_q;
    logic [`STARTUP_CNT_W-1:0] count_d;
    logic running_q;
    logic running_d;
    logic done_q;
    logic done_d;

    // ==========================================================
    // Counter
    always_comb begin
        count_d = count_q;
        running_d = running_q;
        done_d = 1'b0;
        if (tmr.start) begin
            count_d = `STARTUP_CNT_W'(`STARTUP_CYCLES);
            running_d = 1'b1;
        end else if (running_q) begin
            if (count_q == `STARTUP_CNT_W'(1)) begin
                running_d = 1'b0;
                done_d = 1'b1;
            end
            count_d = count_q - `STARTUP_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_q <= '0;
            running_q <= 1'b0;
            done_q <= 1'b0;
        end else if (i_clock_en) begin
            count_q <= count_d;
            running_q <= running_d;
            done_q <= done_d;
        end
    end

    assign tmr.done = done_q;

endmodule

// ---- hw/idle_power_control.sv ----
// Idle and power-down sequencer with its power control register on APB
//
// Contract
// R1: Sleep bit gates off CPU clock
// R2: CPU state held by clock gating
// R3: Port outputs frozen while idle
// R4: Peripheral clock runs during idle
// R5: Watchdog in idle follows run bit
// R6: Supply drop detector active during idle
// R7: Enabled interrupt or reset ends idle
// R8: Wake by interrupt requests service at once
// R9: Hardware clears sleep bit on wake
// R10: Power-down bit starts, cleared on wake
// R11: Wake select: external or timed wake
// R12: Cold flag set by power-up only; the code also lets an APB write set or clear bit 4
// R13: Baud doubler doubles serial rate
// R14: View select muxes serial top bit
// R15: Register at 87H, resets 000X0000, byte-wide
// R16: Spare flags are plain storage
// R17: Timed wake holds clock until timer
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "idle_power_control_regs.svh"

module idle_power_control (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_clock_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`APB_ADDR_W-1:0] i_paddr,
    input wire logic [`APB_DATA_W-1:0] i_pwdata,
    output logic [`APB_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_warm_reset,
    input wire logic i_wake_pin_n,
    input wire logic i_wake_pin_enable,
    input wire logic [7:0] i_irq_pending,
    input wire logic [7:0] i_irq_enable,
    input wire logic i_uart_mode_bit_low,
    input wire logic i_frame_error_flag,
    output logic o_cpu_clock_en,
    output logic o_port_hold,
    output logic o_periph_clock_en,
    output logic o_oscillator_run,
    output logic o_watchdog_run,
    output logic o_supply_drop_enable,
    output logic o_service_request,
    output logic o_baud_double,
    output logic o_serial_top_bit,
    output logic o_cold_start_flag
);

    // ==========================================================
    // Pin synchronisers
    logic warm_sync1_q;
    logic warm_sync2_q;
    logic wake_sync1_q;
    logic wake_sync2_q;
    logic wake_prev_q;
    logic warm_sync1_d;
    logic warm_sync2_d;
    logic wake_sync1_d;
    logic wake_sync2_d;
    logic wake_prev_d;
    logic wake_fall;
    logic wake_rise;

    always_comb begin
        warm_sync1_d = i_warm_reset;
        warm_sync2_d = warm_sync1_q;
        wake_sync1_d = i_wake_pin_n;
        wake_sync2_d = wake_sync1_q;
        wake_prev_d = wake_sync2_q;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            warm_sync1_q <= 1'b0;
            warm_sync2_q <= 1'b0;
            wake_sync1_q <= 1'b1;
            wake_sync2_q <= 1'b1;
            wake_prev_q <= 1'b1;
        end else if (i_clock_en) begin
            warm_sync1_q <= warm_sync1_d;
            warm_sync2_q <= warm_sync2_d;
            wake_sync1_q <= wake_sync1_d;
            wake_sync2_q <= wake_sync2_d;
            wake_prev_q <= wake_prev_d;
        end
    end

    assign wake_fall = wake_prev_q & ~wake_sync2_q & i_wake_pin_enable;
    assign wake_rise = ~wake_prev_q & wake_sync2_q;

    // ==========================================================
    // APB slave
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [`APB_DATA_W-1:0] prdata_q;
    logic [`APB_DATA_W-1:0] prdata_d;
    logic [`WORD_INDEX_W-1:0] word_index;
    logic access;
    logic wr_fire;
    logic hit_power;
    logic hit_watchdog;
    logic hit_status;

    idle_power_control_pkg::power_control_t power_control_q;
    idle_power_control_pkg::power_control_t power_control_d;
    idle_power_control_pkg::power_state_e state_q;
    idle_power_control_pkg::power_state_e state_d;
    logic watchdog_ctrl_q;
    logic watchdog_ctrl_d;
    logic [`APB_DATA_W-1:0] status_word;

    assign word_index = i_paddr[`APB_ADDR_W-1:2];
    assign access = i_psel & i_penable;
    assign wr_fire = access & pready_q & i_pwrite;
    assign hit_power = (word_index == `POWER_CONTROL_INDEX); // R15
    assign hit_watchdog = (word_index == `WATCHDOG_CTRL_INDEX);
    assign hit_status = (word_index == `SLEEP_STATUS_INDEX);

    always_comb begin
        status_word = '0;
        status_word[`STATUS_STATE_MSB:`STATUS_STATE_LSB] = state_q;
        status_word[`STATUS_CPU_GATED] = ~o_cpu_clock_en;
        status_word[`STATUS_WAKE_PIN] = wake_sync2_q;
    end

    always_comb begin
        pready_d = access & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = '0;
        if (access & ~pready_q) begin
            if (hit_power) begin
                prdata_d = {24'h000000, power_control_q};
            end else if (hit_watchdog) begin
                prdata_d[`WATCHDOG_SLEEP_RUN] = watchdog_ctrl_q;
            end else if (hit_status) begin
                prdata_d = status_word;
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (i_clock_en) begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ==========================================================
    // Start-up timer
    startup_timer_if tmr_if ();
    logic tmr_start_q;
    logic tmr_start_d;

    assign tmr_if.start = tmr_start_q;

    startup_timer u_startup_timer (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_clock_en(i_clock_en),
        .tmr(tmr_if.timer)
    );

    // ==========================================================
    // Sequencer and control registers
    logic timed_wake_q;
    logic timed_wake_d;
    logic service_d;
    logic irq_wake;

    assign irq_wake = |(i_irq_pending & i_irq_enable); // R7

    always_comb begin
        state_d = state_q;
        power_control_d = power_control_q;
        watchdog_ctrl_d = watchdog_ctrl_q;
        timed_wake_d = timed_wake_q;
        tmr_start_d = 1'b0;
        service_d = 1'b0;
        if (wr_fire && hit_power) begin
            power_control_d = i_pwdata[7:0]; // R12 R16
        end
        if (wr_fire && hit_watchdog) begin
            watchdog_ctrl_d = i_pwdata[`WATCHDOG_SLEEP_RUN];
        end
        case (state_q)
            idle_power_control_pkg::st_run: begin
                if (power_control_q[`POWER_DOWN_REQUEST]) begin
                    state_d = idle_power_control_pkg::st_power_down; // R10
                end else if (power_control_q[`SLEEP_CPU_CLOCK_BIT]) begin
                    state_d = idle_power_control_pkg::st_idle; // R1
                end
            end
            idle_power_control_pkg::st_idle: begin
                if (irq_wake) begin
                    state_d = idle_power_control_pkg::st_run; // R7
                    power_control_d[`SLEEP_CPU_CLOCK_BIT] = 1'b0; // R9
                    service_d = 1'b1; // R8
                end
            end
            idle_power_control_pkg::st_power_down: begin
                if (wake_fall) begin
                    state_d = idle_power_control_pkg::st_wake_wait;
                    timed_wake_d = power_control_q[`WAKE_TIMING_SELECT]; // R11
                    tmr_start_d = power_control_q[`WAKE_TIMING_SELECT]; // R17
                end
            end
            idle_power_control_pkg::st_wake_wait: begin
                if ((timed_wake_q && tmr_if.done) || (!timed_wake_q && wake_rise)) begin
                    state_d = idle_power_control_pkg::st_run; // R11 R17
                    power_control_d[`POWER_DOWN_REQUEST] = 1'b0; // R10
                    power_control_d[`SLEEP_CPU_CLOCK_BIT] = 1'b0;
                    service_d = 1'b1; // R8
                end
            end
            default: begin
                state_d = idle_power_control_pkg::st_run;
            end
        endcase
        if (warm_sync2_q) begin
            state_d = idle_power_control_pkg::st_run; // R7
            power_control_d = `POWER_CONTROL_RESET;
            power_control_d[`COLD_START_FLAG] = power_control_q[`COLD_START_FLAG]; // R12
            watchdog_ctrl_d = `WATCHDOG_CTRL_RESET;
            timed_wake_d = 1'b0;
            tmr_start_d = 1'b0;
            service_d = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= idle_power_control_pkg::st_run;
            power_control_q <= `POWER_CONTROL_RESET | (8'h01 << `COLD_START_FLAG); // R12 R15
            watchdog_ctrl_q <= `WATCHDOG_CTRL_RESET;
            timed_wake_q <= 1'b0;
            tmr_start_q <= 1'b0;
        end else if (i_clock_en) begin
            state_q <= state_d;
            power_control_q <= power_control_d;
            watchdog_ctrl_q <= watchdog_ctrl_d;
            timed_wake_q <= timed_wake_d;
            tmr_start_q <= tmr_start_d;
        end
    end

    // ==========================================================
    // Registered outputs
    logic cpu_clock_en_q;
    logic port_hold_q;
    logic periph_clock_en_q;
    logic oscillator_run_q;
    logic watchdog_run_q;
    logic supply_drop_enable_q;
    logic service_q;
    logic serial_top_bit_q;
    logic cpu_clock_en_d;
    logic port_hold_d;
    logic periph_clock_en_d;
    logic oscillator_run_d;
    logic watchdog_run_d;
    logic supply_drop_enable_d;
    logic serial_top_bit_d;
    logic running_next;
    logic idle_next;

    always_comb begin
        running_next = (state_d == idle_power_control_pkg::st_run);
        idle_next = (state_d == idle_power_control_pkg::st_idle);
        cpu_clock_en_d = running_next; // R1 R2 R17
        port_hold_d = ~running_next; // R3
        periph_clock_en_d = running_next | idle_next; // R4
        oscillator_run_d = running_next | idle_next | (state_d == idle_power_control_pkg::st_wake_wait);
        watchdog_run_d = running_next | (idle_next & watchdog_ctrl_d); // R5
        supply_drop_enable_d = running_next | idle_next; // R6
        serial_top_bit_d = power_control_q[`FRAME_ERROR_VIEW_SELECT] ? i_frame_error_flag
                                                                     : i_uart_mode_bit_low; // R14
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cpu_clock_en_q <= 1'b1;
            port_hold_q <= 1'b0;
            periph_clock_en_q <= 1'b1;
            oscillator_run_q <= 1'b1;
            watchdog_run_q <= 1'b1;
            supply_drop_enable_q <= 1'b1;
            service_q <= 1'b0;
            serial_top_bit_q <= 1'b0;
        end else if (i_clock_en) begin
            cpu_clock_en_q <= cpu_clock_en_d;
            port_hold_q <= port_hold_d;
            periph_clock_en_q <= periph_clock_en_d;
            oscillator_run_q <= oscillator_run_d;
            watchdog_run_q <= watchdog_run_d;
            supply_drop_enable_q <= supply_drop_enable_d;
            service_q <= service_d;
            serial_top_bit_q <= serial_top_bit_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_cpu_clock_en = cpu_clock_en_q;
    assign o_port_hold = port_hold_q;
    assign o_periph_clock_en = periph_clock_en_q;
    assign o_oscillator_run = oscillator_run_q;
    assign o_watchdog_run = watchdog_run_q;
    assign o_supply_drop_enable = supply_drop_enable_q;
    assign o_service_request = service_q;
    assign o_baud_double = power_control_q[`BAUD_DOUBLER]; // R13
    assign o_serial_top_bit = serial_top_bit_q;
    assign o_cold_start_flag = power_control_q[`COLD_START_FLAG];

endmodule

// ---- verification/idle_power_control_checker.sv ----
// Port-level assertions for the power control block
`timescale 1ns/100ps
`include "idle_power_control_regs.svh"

module idle_power_control_checker (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_clock_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`APB_ADDR_W-1:0] i_paddr,
    input wire logic [`APB_DATA_W-1:0] i_pwdata,
    input wire logic [`APB_DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_warm_reset,
    input wire logic [7:0] i_irq_pending,
    input wire logic [7:0] i_irq_enable,
    input wire logic i_uart_mode_bit_low,
    input wire logic i_frame_error_flag,
    input wire logic o_cpu_clock_en,
    input wire logic o_port_hold,
    input wire logic o_periph_clock_en,
    input wire logic o_supply_drop_enable,
    input wire logic o_service_request,
    input wire logic o_baud_double,
    input wire logic o_serial_top_bit,
    input wire logic o_cold_start_flag
);
    localparam logic [11:0] PC_A = {`POWER_CONTROL_INDEX, 2'b00};
    wire logic mapped = i_paddr == PC_A || i_paddr == PC_A + 12'h004 || i_paddr == PC_A + 12'h008;
    wire logic pc_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == PC_A;
    wire logic irq_wake = |(i_irq_pending & i_irq_enable);
    wire logic gated = !o_cpu_clock_en && o_port_hold && o_periph_clock_en;

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n || !i_clock_en);

    // ==========================================
    // Bus answer
    sequence s_setup; i_psel && !i_penable; endsequence
    sequence s_answer; !o_pready ##1 o_pready; endsequence
    property p_wait; s_setup |=> s_answer; endproperty
    a_wait: assert property (p_wait) else $error("pready timing wrong");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_err; o_pready && !mapped |-> o_pslverr && o_prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_ok; o_pready && mapped |-> !o_pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_reset; $rose(i_arst_n) |-> o_cold_start_flag && o_cpu_clock_en; endproperty
    a_reset: assert property (p_reset) else $error("bad reset outputs");

    // ==========================================
    // Option bits
    property p_bits;
        pc_wr |=> ##1 o_baud_double == $past(i_pwdata[7], 2) && o_cold_start_flag == $past(i_pwdata[4], 2);
    endproperty
    a_bits: assert property (p_bits) else $error("option bits wrong");
    property p_view;
        pc_wr |=> ##1 o_serial_top_bit == ($past(i_pwdata[6], 2) ? $past(i_frame_error_flag)
            : $past(i_uart_mode_bit_low));
    endproperty
    a_view: assert property (p_view) else $error("serial top bit wrong");

    // ==========================================
    // Idle entry and wake
    sequence s_sleep_wr; pc_wr && i_pwdata[1:0] == 2'b01 && o_cpu_clock_en && !i_warm_reset; endsequence
    sequence s_idle; gated && o_supply_drop_enable; endsequence
    property p_idle_in; s_sleep_wr |=> ##1 s_idle; endproperty
    a_idle_in: assert property (p_idle_in) else $error("idle not entered");
    property p_wake; $rose(irq_wake) && gated |=> o_cpu_clock_en && o_service_request && !o_port_hold;
    endproperty
    a_wake: assert property (p_wake) else $error("idle wake wrong");
    property p_hold; gated && !irq_wake && !$past(irq_wake) && !i_warm_reset |=> !o_cpu_clock_en; endproperty
    a_hold: assert property (p_hold) else $error("idle left early");
endmodule

bind idle_power_control idle_power_control_checker chk_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_clock_en(i_clock_en), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_warm_reset(i_warm_reset), .i_irq_pending(i_irq_pending), .i_irq_enable(i_irq_enable),
    .i_uart_mode_bit_low(i_uart_mode_bit_low), .i_frame_error_flag(i_frame_error_flag),
    .o_cpu_clock_en(o_cpu_clock_en), .o_port_hold(o_port_hold), .o_periph_clock_en(o_periph_clock_en),
    .o_supply_drop_enable(o_supply_drop_enable), .o_service_request(o_service_request),
    .o_baud_double(o_baud_double), .o_serial_top_bit(o_serial_top_bit), .o_cold_start_flag(o_cold_start_flag));

// ---- verification/tb_top.sv ----
// Self-checking bench for the power control block
`timescale 1ns/100ps
`include "idle_power_control_regs.svh"

module tb_top;
    localparam logic [11:0] pc_addr = {`POWER_CONTROL_INDEX, 2'b00};
    localparam logic [11:0] wd_addr = {`WATCHDOG_CTRL_INDEX, 2'b00};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic warm = 1'b0;
    logic pin_n = 1'b1;
    logic [7:0] pend = 8'h00;
    logic [7:0] en = 8'h00;
    logic uml = 1'b0;
    logic fe = 1'b0;
    logic ce = 1'b1;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, err, cpu_en, hold, periph, osc, wdog, sdrop, srv, baud, stop, cold;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    idle_power_control uut (.i_clock(clk), .i_arst_n(rst_n), .i_clock_en(ce), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_warm_reset(warm), .i_wake_pin_n(pin_n),
        .i_wake_pin_enable(1'b1), .i_irq_pending(pend), .i_irq_enable(en), .i_uart_mode_bit_low(uml),
        .i_frame_error_flag(fe), .o_cpu_clock_en(cpu_en), .o_port_hold(hold), .o_periph_clock_en(periph),
        .o_oscillator_run(osc), .o_watchdog_run(wdog), .o_supply_drop_enable(sdrop),
        .o_service_request(srv), .o_baud_double(baud), .o_serial_top_bit(stop), .o_cold_start_flag(cold));

    // ==========================================
    // Shared tasks
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Sampled at the edge itself, before the design updates
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Waits for the CPU clock, returns the negedge count
    task automatic wait_cpu(input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cpu_en !== 1'b1 && n < lim);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs();
        apb(0, pc_addr, 0);
        chk(rdata, 32'h10);
        chk1(cold, 1'b1);
        apb(1, pc_addr, 32'hffff_ffcc);
        apb(1, pc_addr + 12'h00c, 32'h0000_0000);
        chk1(err, 1'b1);
        apb(0, pc_addr + 12'h00c, 0);
        chk(rdata, 32'h0);
        apb(0, pc_addr, 0);
        chk(rdata, 32'hcc);
        chk1(err, 1'b0);
    endtask

    task automatic t_view();
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            fe <= 1'b1;
            uml <= 1'b0;
            apb(1, pc_addr, {24'h0, v[0], v[0], 6'h0});
            cyc(2);
            chk1(stop, v[0]);
            chk1(baud, v[0]);
        end
    endtask

    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        uml <= 1'b1;
        cyc(4);
        chk1(stop, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        cyc(2);
        chk1(stop, 1'b1);
    endtask

    task automatic t_warm();
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            d = (i == 0) ? 8'h94 : 8'h84;
            apb(1, pc_addr, {24'h0, d});
            @(posedge clk);
            warm <= 1'b1;
            repeat (2) @(posedge clk);
            warm <= 1'b0;
            cyc(8);
            apb(0, pc_addr, 0);
            chk(rdata, {24'h0, d & 8'h10});
        end
        // Power-up reset in mid-run sets the cold flag again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, pc_addr, 0);
        chk(rdata, 32'h10);
    endtask

    task automatic t_idle(input logic wd);
        int n;
        apb(1, wd_addr, {31'h0, wd});
        @(posedge clk);
        en <= 8'h04;
        pend <= 8'h01;
        apb(1, pc_addr, 32'h01);
        cyc(4);
        chk({27'h0, cpu_en, hold, periph, sdrop, wdog}, {27'h0, 4'b0111, wd});
        apb(0, pc_addr, 0);
        chk(rdata, 32'h01);
        cyc(20);
        chk1(cpu_en, 1'b0);
        @(posedge clk);
        pend <= 8'h05;
        wait_cpu(10, n);
        chk(32'(n), 32'd2);
        chk1(srv, 1'b1);
        @(posedge clk);
        pend <= 8'h00;
        apb(0, pc_addr, 0);
        chk(rdata, 32'h0);
    endtask

    task automatic t_pd(input logic timed);
        int n;
        apb(1, pc_addr, {26'h0, timed, 5'h02});
        cyc(4);
        chk({28'h0, osc, sdrop, cpu_en, hold}, 32'h1);
        apb(0, pc_addr + 12'h008, 0);
        chk(rdata, 32'h0e);
        @(posedge clk);
        pin_n <= 1'b0;
        cyc(30);
        chk1(cpu_en, 1'b0);
        @(posedge clk);
        pin_n <= 1'b1;
        wait_cpu(800, n);
        chk1(timed ? (n > 600 && n < 700) : (n < 10), 1'b1);
        chk1(srv, 1'b1);
        apb(0, pc_addr, 0);
        chk(rdata, {26'h0, timed, 5'h00});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_view();
        t_freeze();
        t_warm();
        t_idle(1'b0);
        t_idle(1'b1);
        t_pd(1'b1);
        t_pd(1'b0);
        print_verdict();
    end
endmodule
